/* File: verilog/cpc_pkg.sv */
// Constants, types and register map of the converter protection control block.
// Assumes a single 40 MHz clock and comparator results synchronous to it.
package cpc_pkg;
  localparam int CLK_HZ          = 40_000_000;
  localparam int FSW_LF_HZ       = 60_000;
  localparam int FSW_HF_HZ       = 115_000;
  localparam int PER_LF          = CLK_HZ / FSW_LF_HZ;
  localparam int PER_HF          = CLK_HZ / FSW_HF_HZ;
  localparam int DMAX_PCT        = 75;
  localparam int OVL_TIME_MS     = 50;
  localparam int OVL_TERM_LF     = OVL_TIME_MS * (FSW_LF_HZ / 1000);
  localparam int OVL_TERM_HF     = OVL_TIME_MS * (FSW_HF_HZ / 1000);
  localparam int RESTART_TIME_S  = 1;
  localparam int RESTART_CLKS    = RESTART_TIME_S * CLK_HZ;
  localparam int SS_TIME_US      = 8500;
  localparam int SS_CLKS         = SS_TIME_US * (CLK_HZ / 1_000_000);
  localparam int LIM_R_OPEN_KOHM = 80;
  localparam int I_LIM_DEF_MA    = 700;
  localparam int I_LIM_BURST_MA  = 145;
  localparam int BURST_EXIT_CYC  = 16;

  localparam int LIM_W = 8;
  localparam int CYC_W = 10;
  localparam int OVL_W = 13;
  localparam int RST_W = 26;
  localparam int SSD_W = 19;
  localparam int BQ_W  = 5;

  localparam logic [LIM_W-1:0] LIM_DEF_CODE   = 8'hFF;
  localparam logic [LIM_W-1:0] LIM_BURST_CODE = LIM_W'(I_LIM_BURST_MA * 255 / I_LIM_DEF_MA);

  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_OVL    = 4'h8;
  localparam logic [3:0] OFS_LIMIT  = 4'hC;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_HF_BIT = 1;

  typedef enum logic [1:0] {MODE_OFF, MODE_RUN, MODE_WAIT} cpc_mode_t;

  typedef struct packed {
    logic             pwm_trip;
    logic             ocp_trip;
    logic             comp_below_burst;
    logic             comp_above_hys;
    logic             comp_above_sat;
    logic             fb_grounded;
    logic             fb_floating;
    logic             limit_open;
    logic             clamp_over;
    logic [LIM_W-1:0] sink_code;
  } cpc_sense_t;

  typedef struct packed {
    cpc_mode_t        mode;
    logic             en;
    logic             hf;
    logic [CYC_W-1:0] cyc;
    logic             gate;
    logic             limit_seen;
    logic             burst_hold;
    logic             burst_regime;
    logic [BQ_W-1:0]  burst_quiet;
    logic [OVL_W-1:0] ovl;
    logic             ovl_trip;
    logic             ol_fault;
    logic [RST_W-1:0] rst_cnt;
    logic [LIM_W-1:0] ss_level;
    logic [SSD_W-1:0] ss_div;
    logic [LIM_W-1:0] limit_set_input;
    logic             err_amp_en;
    logic             int_ref_en;
    logic             fb_pullup;
    logic             wreq;
    logic [31:0]      rdata;
  } cpc_state_t;
endpackage

/* File: verilog/cpc_top.sv */
// Switching control and protection of an off-line PWM converter, with Avalon-MM registers.
// Assumes comparator results arrive synchronous to clk_i; limit_code_o feeds the overcurrent DAC.
module cpc_top
  import cpc_pkg::*;
#(
  parameter int RESTART_CLKS_P = RESTART_CLKS,
  parameter int SS_CLKS_P      = SS_CLKS
) (
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  input  wire logic             ce_i,
  input  wire cpc_sense_t       sense_i,
  input  wire logic [3:0]       address_i,
  input  wire logic             read_i,
  input  wire logic             write_i,
  input  wire logic [31:0]      writedata_i,
  input  wire logic [3:0]       byteenable_i,
  output logic [31:0]           readdata_o,
  output logic                  waitrequest_o,
  output logic                  gate_on_o,
  output logic [LIM_W-1:0]      limit_code_o,
  output logic                  err_amp_en_o,
  output logic                  int_ref_en_o,
  output logic                  fb_pullup_en_o
);
  localparam int SS_STEP = (SS_CLKS_P / 256 < 1) ? 1 : SS_CLKS_P / 256;

  cpc_state_t st;
  cpc_state_t next_st;
  logic       tick;
  logic       seen;
  logic       limit_now;

  function automatic logic [CYC_W-1:0] period_m1(input logic hf);
    return hf ? CYC_W'(PER_HF - 1) : CYC_W'(PER_LF - 1);
  endfunction

  function automatic logic [CYC_W-1:0] dmax_cyc(input logic hf);
    return hf ? CYC_W'(PER_HF * DMAX_PCT / 100) : CYC_W'(PER_LF * DMAX_PCT / 100);
  endfunction

  function automatic logic [OVL_W-1:0] ovl_term(input logic hf);
    return hf ? OVL_W'(OVL_TERM_HF) : OVL_W'(OVL_TERM_LF);
  endfunction

  function automatic logic [LIM_W-1:0] min_code(input logic [LIM_W-1:0] a, input logic [LIM_W-1:0] b);
    return (a < b) ? a : b;
  endfunction

  // Sunk current lowers the limit one code per code; resistor above the open level reads as open.
  function automatic logic [LIM_W-1:0] lim_target(input logic open, input logic [LIM_W-1:0] sink);
    return open ? LIM_DEF_CODE : LIM_W'(LIM_DEF_CODE - sink);
  endfunction

  always_comb begin
    next_st   = st;
    tick      = (st.cyc >= period_m1(st.hf));
    limit_now = st.gate & sense_i.ocp_trip;
    seen      = st.limit_seen | limit_now;
    if (ce_i) begin
      // Bus slave: one wait cycle, then the access completes
      next_st.wreq = ~((read_i | write_i) & st.wreq);
      if (read_i & st.wreq) begin
        unique case (address_i)
          OFS_CTRL:   next_st.rdata = {30'h0000_0000, st.hf, st.en};
          OFS_STATUS: next_st.rdata = {23'h00_0000, st.mode == MODE_WAIT, st.ss_level != LIM_DEF_CODE,
                                       st.ol_fault, st.ovl_trip, st.int_ref_en, st.burst_regime,
                                       st.burst_hold, st.gate, st.mode == MODE_RUN};
          OFS_OVL:    next_st.rdata = {19'h0_0000, st.ovl};
          OFS_LIMIT:  next_st.rdata = {24'h00_0000, st.limit_set_input};
          default:    next_st.rdata = 32'h0000_0000;
        endcase
      end
      if (write_i & ~st.wreq & (address_i == OFS_CTRL) & byteenable_i[0]) begin
        next_st.en = writedata_i[CTRL_EN_BIT];
        next_st.hf = writedata_i[CTRL_HF_BIT];
      end

      next_st.err_amp_en = ~sense_i.fb_grounded;
      next_st.int_ref_en = sense_i.fb_grounded;
      next_st.fb_pullup  = 1'b1;

      next_st.cyc = tick ? '0 : CYC_W'(st.cyc + 1'b1);

      if (sense_i.comp_below_burst) begin
        next_st.burst_hold   = 1'b1;
        next_st.burst_regime = 1'b1;
        next_st.burst_quiet  = '0;
      end else if (sense_i.comp_above_hys) begin
        next_st.burst_hold = 1'b0;
      end
      // Burst limit stays until a run of cycles with no burst entry
      if (tick & st.burst_regime & ~st.burst_hold & ~sense_i.comp_below_burst) begin
        next_st.burst_quiet = BQ_W'(st.burst_quiet + 1'b1);
        if (st.burst_quiet == BQ_W'(BURST_EXIT_CYC - 1)) begin
          next_st.burst_regime = 1'b0;
        end
      end

      next_st.limit_set_input = min_code(st.burst_regime ? min_code(lim_target(sense_i.limit_open, sense_i.sink_code),
                                                        LIM_BURST_CODE)
                                             : lim_target(sense_i.limit_open, sense_i.sink_code),
                             st.ss_level);

      if (st.mode == MODE_RUN && st.ss_level != LIM_DEF_CODE) begin
        next_st.ss_div = SSD_W'(st.ss_div + 1'b1);
        if (st.ss_div >= SSD_W'(SS_STEP - 1)) begin
          next_st.ss_div   = '0;
          next_st.ss_level = LIM_W'(st.ss_level + 1'b1);
        end
      end

      // Saturated compensation cannot end the pulse; the limit or the maximum duty cycle does
      if (st.gate & sense_i.pwm_trip & ~sense_i.comp_above_sat) begin
        next_st.gate = 1'b0;
      end
      if (limit_now) begin
        next_st.gate       = 1'b0;
        next_st.limit_seen = 1'b1;
      end
      if (st.cyc == dmax_cyc(st.hf)) begin
        next_st.gate = 1'b0;
      end

      unique case (st.mode)
        MODE_OFF: begin
          next_st.gate = 1'b0;
          if (st.en) begin
            next_st.mode     = MODE_RUN;
            next_st.ss_level = '0;
            next_st.ss_div   = '0;
            next_st.ovl      = '0;
          end
        end
        MODE_RUN: begin
          if (tick) begin
            next_st.limit_seen = 1'b0;
            if (seen) begin
              if (st.ovl != ovl_term(st.hf)) begin
                next_st.ovl = OVL_W'(st.ovl + 1'b1);
              end
            end else if (st.ovl != '0) begin
              next_st.ovl = OVL_W'(st.ovl - 1'b1);
            end
            next_st.gate = ~st.burst_hold & ~sense_i.comp_below_burst & ~sense_i.fb_floating;
          end
          if (tick & seen & (st.ovl >= OVL_W'(ovl_term(st.hf) - 1'b1))) begin
            next_st.mode     = MODE_WAIT;
            next_st.ovl_trip = 1'b1;
            next_st.gate     = 1'b0;
            next_st.rst_cnt  = RST_W'(RESTART_CLKS_P - 1);
          end
          if (limit_now & sense_i.clamp_over) begin
            next_st.mode     = MODE_WAIT;
            next_st.ol_fault = 1'b1;
            next_st.gate     = 1'b0;
            next_st.rst_cnt  = RST_W'(RESTART_CLKS_P - 1);
          end
          if (~st.en) begin
            next_st.mode = MODE_OFF;
            next_st.gate = 1'b0;
          end
        end
        MODE_WAIT: begin
          next_st.gate = 1'b0;
          next_st.rst_cnt = RST_W'(st.rst_cnt - 1'b1);
          if (st.rst_cnt == '0) begin
            next_st.mode       = st.en ? MODE_RUN : MODE_OFF;
            next_st.ss_level   = '0;
            next_st.ss_div     = '0;
            next_st.ovl        = '0;
            next_st.limit_seen = 1'b0;
            next_st.ovl_trip   = 1'b0;
            next_st.ol_fault   = 1'b0;
          end
        end
      endcase

      // Held off at once in burst or with a floating feedback
      if (sense_i.comp_below_burst | st.burst_hold | sense_i.fb_floating) begin
        next_st.gate = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st            <= '0;
      st.mode       <= MODE_OFF;
      st.wreq       <= 1'b1;
      st.err_amp_en <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign readdata_o     = st.rdata;
  assign waitrequest_o  = st.wreq;
  assign gate_on_o      = st.gate;
  assign limit_code_o   = st.limit_set_input;
  assign err_amp_en_o   = st.err_amp_en;
  assign int_ref_en_o   = st.int_ref_en;
  assign fb_pullup_en_o = st.fb_pullup;

  sequence s_wait_end;
    st.mode == MODE_WAIT ##1 st.mode == MODE_RUN;
  endsequence

  sequence s_trip_cycle;
    ce_i && st.en && tick && seen && st.mode == MODE_RUN && st.ovl == OVL_W'(ovl_term(st.hf) - 1'b1);
  endsequence

  a_pwm_ends_pulse: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && st.gate && sense_i.pwm_trip && !sense_i.comp_above_sat && !tick |=> !st.gate)
    else $error("pulse not ended by pwm trip");
  a_ocp_ends_pulse: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && st.gate && sense_i.ocp_trip && !tick |=> !st.gate && st.limit_seen)
    else $error("pulse not ended by overcurrent");
  a_default_limit: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && sense_i.limit_open && !st.burst_regime && st.ss_level == LIM_DEF_CODE |=> st.limit_set_input == LIM_DEF_CODE)
    else $error("default limit not applied");
  a_burst_limit: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && st.burst_regime |=> st.limit_set_input <= LIM_BURST_CODE)
    else $error("burst limit exceeded");
  a_burst_hold_off: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && sense_i.comp_below_burst |=> !st.gate && st.burst_hold)
    else $error("switch not held off in burst");
  a_ovl_count_down: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && tick && st.mode == MODE_RUN && st.en && !seen && st.ovl != '0 && !sense_i.clamp_over
    |=> st.ovl == OVL_W'($past(st.ovl) - 1'b1))
    else $error("overload counter did not step down");
  a_ovl_trip_stop: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_trip_cycle |=> st.mode == MODE_WAIT && !st.gate && st.ovl_trip)
    else $error("overload did not stop switching");
  a_restart_soft: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_wait_end |-> st.ss_level == '0 && st.ovl == '0)
    else $error("restart without fresh soft start");
  a_fault_both: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(st.ol_fault) |-> $past(st.gate && sense_i.ocp_trip && sense_i.clamp_over))
    else $error("open-loop fault without both conditions");
  a_isolated_mode: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && sense_i.fb_grounded |=> !err_amp_en_o && int_ref_en_o)
    else $error("isolated mode not applied");
  a_bus_one_wait: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && (read_i || write_i) && st.wreq |=> !st.wreq)
    else $error("bus answer late");
endmodule

/* File: sim/cpc_conv_model.sv */
// Behavioural power switch and current comparators at the far side of the block.
// Assumes gate and limit code come from the block; the bench sets the static senses.
module cpc_conv_model
  import cpc_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  input  wire logic             gate_i,
  input  wire logic [LIM_W-1:0] limit_i,
  input  wire logic [CYC_W-1:0] comp_lvl_i,
  input  wire cpc_sense_t       cfg_i,
  output cpc_sense_t            sense_o
);
  logic [CYC_W-1:0] cur;

  // Drain current ramps one step a clock while on, collapses when off
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cur <= '0;
    end else if (gate_i) begin
      cur <= cur + 1'b1;
    end else begin
      cur <= '0;
    end
  end

  // Board-level senses pass through; grounded feedback is a board choice
  always_comb begin
    sense_o          = cfg_i;
    sense_o.pwm_trip = gate_i && (cur >= comp_lvl_i);
    sense_o.ocp_trip = gate_i && (cur >= {2'b00, limit_i});
  end
endmodule

/* File: sim/tb_top.sv */
// Self-checking bench for the converter protection block.
// Assumes the behavioural switch model; restart and soft start shortened.
module tb_top
  import cpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clk_i, resetn_i, rd, wr, wreq, gate, eae, ire, fpu, f_q, seen;
  logic [3:0]       addr;
  logic [31:0]      wdata, rdata, q, a, b;
  logic [LIM_W-1:0] limit_set_input;
  logic [CYC_W-1:0] comp_lvl;
  cpc_sense_t       cfg, sense;
  int               err_total, checked, n, m;

  cpc_top #(.RESTART_CLKS_P(2000), .SS_CLKS_P(512)) u_dut (.clk_i(clk_i), .resetn_i(resetn_i),
    .ce_i(1'b1), .sense_i(sense), .address_i(addr), .read_i(rd), .write_i(wr), .writedata_i(wdata),
    .byteenable_i(4'hF), .readdata_o(rdata), .waitrequest_o(wreq), .gate_on_o(gate),
    .limit_code_o(limit_set_input), .err_amp_en_o(eae), .int_ref_en_o(ire), .fb_pullup_en_o(fpu));
  cpc_conv_model u_model (.clk_i(clk_i), .resetn_i(resetn_i), .gate_i(gate), .limit_i(limit_set_input),
    .comp_lvl_i(comp_lvl), .cfg_i(cfg), .sense_o(sense));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // Avalon access: hold the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] ad, input logic [31:0] d, output logic [31:0] r);
    int k;
    @(posedge clk_i);
    addr  <= ad;
    wdata <= d;
    rd    <= !w;
    wr    <= w;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (wreq !== 1'b0 && k < 50);
    if (k >= 50) check(1'b1, 1'b0, "bus timeout");
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wait_rise(input int lim_c, output logic s);
    s = 1'b0;
    repeat (lim_c) begin
      @(negedge clk_i);
      if (gate === 1'b1) begin
        s = 1'b1;
        break;
      end
    end
  endtask

  task automatic on_time(output int t);
    // Skip a pulse already in progress so the whole pulse is measured
    while (gate === 1'b1) @(negedge clk_i);
    wait_rise(800, seen);
    t = 1;
    do begin
      @(negedge clk_i);
      if (gate === 1'b1) t++;
    end while (gate === 1'b1 && t < 400);
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // An overcurrent trip, or a pwm trip with unsaturated compensation, while on must end the pulse on the next edge
  always @(posedge clk_i) begin
    if (resetn_i && f_q) check(gate, 1'b0, "gate after trip");
    f_q <= resetn_i && gate && (sense.ocp_trip || (sense.pwm_trip && !sense.comp_above_sat));
  end

  initial begin
    repeat (60000) @(posedge clk_i);
    err_total++;
    $display("ERROR at %0t: watchdog expired", $time);
    results();
  end

  initial begin
    resetn_i = 1'b0;
    {rd, wr, f_q} = '0;
    addr = '0;
    wdata = '0;
    cfg = '0;
    cfg.limit_open = 1'b1;
    cfg.comp_above_hys = 1'b1;
    cfg.sink_code = 8'h40;
    comp_lvl = 10'd40;
    #30;
    check({wreq, eae, gate, fpu}, 4'b1100, "reset outputs");
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    bus(1'b0, OFS_CTRL, '0, q);
    check(q, 32'h0000_0000, "ctrl reset");
    bus(1'b1, OFS_STATUS, 32'hFFFF_FFFF, q);
    bus(1'b0, OFS_STATUS, '0, q);
    check(q, 32'h0000_0080, "status write ignored");
    bus(1'b1, OFS_CTRL, 32'h0000_0003, q);
    bus(1'b0, OFS_CTRL, '0, q);
    check(q, 32'h0000_0003, "ctrl readback");
    check(limit_set_input < 8'h10, 1'b1, "soft start low");
    check(fpu, 1'b1, "pull-up on");
    $display("register test done");
    repeat (600) @(posedge clk_i);
    check(limit_set_input, 8'hFF, "open limit input");
    cfg.limit_open <= 1'b0;
    repeat (4) @(posedge clk_i);
    bus(1'b0, OFS_LIMIT, '0, q);
    check(q, 32'h0000_00BF, "limit lowered by sink");
    cfg.limit_open <= 1'b1;
    on_time(n);
    check(n, 41, "pwm on-time");
    @(posedge clk_i);
    cfg.comp_above_sat <= 1'b1;
    on_time(n);
    on_time(n);
    check(n, 256, "saturated on-time at limit");
    @(posedge clk_i);
    cfg.comp_above_sat <= 1'b0;
    $display("limit test done");
    cfg.comp_below_burst <= 1'b1;
    cfg.comp_above_hys <= 1'b0;
    repeat (2) @(posedge clk_i);
    wait_rise(700, seen);
    check(seen, 1'b0, "burst holds off");
    @(posedge clk_i);
    cfg.comp_below_burst <= 1'b0;
    wait_rise(700, seen);
    check(seen, 1'b0, "no resume inside hysteresis");
    @(posedge clk_i);
    cfg.comp_above_hys <= 1'b1;
    wait_rise(400, seen);
    check(seen, 1'b1, "resume above hysteresis");
    check(limit_set_input, LIM_BURST_CODE, "burst limit");
    @(posedge clk_i);
    cfg.fb_floating <= 1'b1;
    repeat (2) @(posedge clk_i);
    wait_rise(700, seen);
    check(seen, 1'b0, "floating feedback stops");
    @(posedge clk_i);
    cfg.fb_floating <= 1'b0;
    cfg.fb_grounded <= 1'b1;
    repeat (3) @(posedge clk_i);
    check({eae, ire}, 2'b01, "isolated mode");
    cfg.fb_grounded <= 1'b0;
    $display("mode test done");
    comp_lvl <= 10'd1000;
    repeat (2 * PER_HF) @(posedge clk_i);
    bus(1'b0, OFS_OVL, '0, a);
    repeat (5 * PER_HF - 3) @(posedge clk_i);
    bus(1'b0, OFS_OVL, '0, b);
    check(b - a, 32'd5, "count up per limit cycle");
    comp_lvl <= 10'd20;
    // Let the cycle that may still hold a limit event finish first
    repeat (PER_HF) @(posedge clk_i);
    bus(1'b0, OFS_OVL, '0, a);
    repeat (5 * PER_HF - 3) @(posedge clk_i);
    bus(1'b0, OFS_OVL, '0, b);
    check(a - b, 32'd5, "count down per clean cycle");
    repeat (12 * PER_HF) @(posedge clk_i);
    bus(1'b0, OFS_OVL, '0, q);
    check(q, 32'h0000_0000, "count floors at zero");
    wait_rise(400, seen);
    check(seen, 1'b1, "still switching");
    $display("overload test done");
    @(posedge clk_i);
    cfg.clamp_over <= 1'b1;
    repeat (2 * PER_HF) @(posedge clk_i);
    bus(1'b0, OFS_STATUS, '0, q);
    check(q[6], 1'b0, "clamp alone no fault");
    comp_lvl <= 10'd1000;
    repeat (2 * PER_HF) @(posedge clk_i);
    bus(1'b0, OFS_STATUS, '0, q);
    check({q[8], q[6], q[1]}, 3'b110, "open-loop fault stops");
    cfg.clamp_over <= 1'b0;
    comp_lvl <= 10'd20;
    n = 0;
    do begin
      bus(1'b0, OFS_STATUS, '0, q);
      n++;
    end while (q[8] && n < 1000);
    check({n > 400, q[8]}, 2'b10, "restart waits delay");
    check(limit_set_input < 8'h10, 1'b1, "restart soft start");
    wait_rise(400, seen);
    check(seen, 1'b1, "restart after delay");
    bus(1'b0, OFS_STATUS, '0, q);
    check(q[7], 1'b1, "soft start flagged");
    $display("fault test done");
    bus(1'b1, OFS_CTRL, 32'h0000_0001, q);
    on_time(n);
    m = 0;
    do begin
      @(negedge clk_i);
      m++;
    end while (gate !== 1'b1 && m < 1000);
    check(m + n, PER_LF, "switching period at 60 kHz");
    $display("frequency test done");
    results();
  end
endmodule
